// ---- pkg/autoreload_timer16_regs.vh ----
`ifndef AUTORELOAD_TIMER16_REGS_VH
`define AUTORELOAD_TIMER16_REGS_VH

// Register indices; byte address is four times the index
`define TMR_CTRL_IDX      8'hc4
`define TMR_RLD_LO_IDX    8'hc5
`define TMR_RLD_HI_IDX    8'hc6
`define TMR_COUNT_IDX     8'hc8
`define TMR_STATUS_IDX    8'hc9
`define TMR_CLEAR_IDX     8'hca
`define TMR_IRQ_EN_IDX    8'hcb

// Control register fields
`define TMR_FLAG_BIT      4
`define TMR_RUN_BIT       3
`define TMR_PS_MSB        2
`define TMR_PS_LSB        0

// Interrupt enable, status and clear share this bit
`define TMR_IRQ_BIT       1

// Reset values
`define TMR_CTRL_RST      8'h00
`define TMR_RLD_LO_RST    8'h00
`define TMR_RLD_HI_RST    8'h00
`define TMR_IRQ_EN_RST    8'h00
`define TMR_COUNT_RST     16'h0000

// Rollover point of the counter
`define TMR_COUNT_MAX     16'hffff

`endif

// ---- hw/autoreload_timer16.v ----
`timescale 1ns/1ns
`default_nettype none
`include "autoreload_timer16_regs.vh"

// Plain software storage; only a bus write changes it.
// Shared by every register that has no hardware update path.
module sw_store_reg #(
   parameter             WIDTH = 8,            // Stored bits
   parameter [WIDTH-1:0] RESET = {WIDTH{1'b0}} // Value after reset
) (
   input  wire             hclk,    // System clock
   input  wire             hresetn, // Asynchronous reset, active low
   input  wire             wr,      // Write strobe of the data phase
   input  wire [WIDTH-1:0] din,     // Write data
   output reg  [WIDTH-1:0] q        // Stored value
);

   // Holds between writes; no hardware event touches it
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= RESET;
      end else if (wr) begin
         q <= din;
      end
   end

endmodule // sw_store_reg

module autoreload_timer16 (
   input  wire        hclk,         // System clock, 50 MHz
   input  wire        hresetn,      // Asynchronous reset, active low
   input  wire        hsel,         // Slave select
   input  wire [31:0] haddr,        // Byte address
   input  wire [1:0]  htrans,       // Transfer type
   input  wire        hwrite,       // Write when high
   input  wire [2:0]  hsize,        // Transfer size
   input  wire [31:0] hwdata,       // Write data
   input  wire        hready,       // Bus ready
   input  wire        overflow_ack, // Service entry strobe
   output reg  [31:0] hrdata,       // Read data
   output reg         hreadyout,    // Slave ready
   output reg         hresp,        // Always OKAY
   output reg         irq,          // Level interrupt
   output reg         baud_tick     // One-cycle overflow pulse
);

   // Bus phase tracking
   reg         wr_pend_reg;
   reg         rd_pend_reg;
   reg  [7:0]  idx_reg;
   wire        accept;
   wire [7:0]  acc_idx;
   wire        addr_ok;

   // Registers seen by software
   reg  [7:0]  ctrl_reg;
   reg  [7:0]  ctrl_next;
   wire [7:0]  rld_lo_reg;
   wire [7:0]  rld_hi_reg;
   wire [7:0]  irq_en_reg;
   reg         status_reg;
   reg         status_next;

   // Counting state
   reg  [15:0] count_reg;
   reg  [15:0] count_next;
   reg  [6:0]  pre_reg;
   wire [6:0]  pre_mask;
   wire        run;
   wire        tick;
   wire        rollover;
   wire [15:0] reload_value;

   // Write strobes of the current data phase
   wire        wr_ctrl;
   wire        wr_lo;
   wire        wr_hi;
   wire        wr_en;
   wire        wr_clr;
   reg  [31:0] rd_mux;

   // Control and enable fields under their own names
   wire [2:0]  prescale_select;
   wire        overflow_irq_enable;

   // Address phase is taken only for word-sized, aligned transfers
   // Misaligned or sub-word requests get no wait and no effect
   assign addr_ok  = (haddr[1:0] == 2'b00) && (hsize == 3'b010);
   assign accept   = hsel && htrans[1] && hready && addr_ok;
   assign acc_idx  = haddr[9:2];

   // Capture address phase; reads get one wait state
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         idx_reg     <= 8'h00;
      end else begin
         wr_pend_reg <= accept && hwrite;
         rd_pend_reg <= accept && !hwrite;
         if (accept) begin
            idx_reg <= acc_idx;
         end
      end
   end

   // Write decode in the data phase
   // At most one data phase is pending, so strobes never overlap
   assign wr_ctrl = wr_pend_reg && (idx_reg == `TMR_CTRL_IDX);
   assign wr_lo   = wr_pend_reg && (idx_reg == `TMR_RLD_LO_IDX);
   assign wr_hi   = wr_pend_reg && (idx_reg == `TMR_RLD_HI_IDX);
   assign wr_en   = wr_pend_reg && (idx_reg == `TMR_IRQ_EN_IDX);
   assign wr_clr  = wr_pend_reg && (idx_reg == `TMR_CLEAR_IDX);

   // Read mux; unmapped and write-only offsets read zero
   always @* begin
      rd_mux = 32'h0000_0000;
      case (idx_reg)
         `TMR_CTRL_IDX:   rd_mux[7:0]  = ctrl_reg;
         `TMR_RLD_LO_IDX: rd_mux[7:0]  = rld_lo_reg;
         `TMR_RLD_HI_IDX: rd_mux[7:0]  = rld_hi_reg;
         `TMR_COUNT_IDX:  rd_mux[15:0] = count_reg;
         `TMR_STATUS_IDX: rd_mux[`TMR_IRQ_BIT] = status_reg;
         `TMR_IRQ_EN_IDX: rd_mux[7:0]  = irq_en_reg;
         default:         rd_mux = 32'h0000_0000;
      endcase
   end

   // Ready drops for the one read wait state; response always OKAY
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hresp <= 1'b0;
         if (accept && !hwrite) begin
            hreadyout <= 1'b0;
         end else begin
            hreadyout <= 1'b1;
         end
      end
   end

   // Read data is sampled in the wait state so a write
   // just before a read is always visible
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_pend_reg) begin
         hrdata <= rd_mux;
      end
   end

   assign run             = ctrl_reg[`TMR_RUN_BIT];
   assign prescale_select = ctrl_reg[`TMR_PS_MSB:`TMR_PS_LSB];

   // Prescaler mask: tick when the low bits are all ones
   // divide by two to the code
   assign pre_mask = ~(7'h7f << prescale_select);
   // Free-running count, so a new code takes effect within one period;
   // code zero ticks on every system clock
   assign tick     = run && ((pre_reg & pre_mask) == pre_mask);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_reg <= 7'h00;
      end else if (!run) begin
         // Restart so the first period after start is whole
         pre_reg <= 7'h00;
      end else begin
         pre_reg <= pre_reg + 7'h01;
      end
   end

   assign reload_value = {rld_hi_reg, rld_lo_reg};
   assign rollover     = tick && (count_reg == `TMR_COUNT_MAX);

   // Counter next value
   always @* begin
      count_next = count_reg;
      if (rollover) begin
         count_next = reload_value;
      end else if (tick) begin
         count_next = count_reg + 16'h0001;
      end
   end

   // Counter is not writable; it starts from zero or from the reload
   // halted unless run is set
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_reg <= `TMR_COUNT_RST;
      end else begin
         count_reg <= count_next;
      end
   end

   // Control register; hardware set wins over any clear
   always @* begin
      ctrl_next = ctrl_reg;
      // Bits 7:5 are plain storage for the serial ports
      if (wr_ctrl) begin
         ctrl_next = hwdata[7:0];
      end
      if (overflow_ack) begin
         ctrl_next[`TMR_FLAG_BIT] = 1'b0;
      end
      if (rollover) begin
         ctrl_next[`TMR_FLAG_BIT] = 1'b1;
      end
   end

   // Sticky status bit, cleared by write-one or service entry
   always @* begin
      status_next = status_reg;
      if ((wr_clr && hwdata[`TMR_IRQ_BIT]) || overflow_ack) begin
         status_next = 1'b0;
      end
      if (rollover) begin
         status_next = 1'b1;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg   <= `TMR_CTRL_RST;
         status_reg <= 1'b0;
      end else begin
         ctrl_reg   <= ctrl_next;
         status_reg <= status_next;
      end
   end

   // low byte of the reload value
   // writes while running are taken as-is, result undefined
   sw_store_reg #(
      .WIDTH (8),
      .RESET (`TMR_RLD_LO_RST)
   ) i_sw_store_reg_lo (
      .hclk    (hclk),
      .hresetn (hresetn),
      .wr      (wr_lo),
      .din     (hwdata[7:0]),
      .q       (rld_lo_reg)
   );

   // high reload byte, zero after reset
   sw_store_reg #(
      .WIDTH (8),
      .RESET (`TMR_RLD_HI_RST)
   ) i_sw_store_reg_hi (
      .hclk    (hclk),
      .hresetn (hresetn),
      .wr      (wr_hi),
      .din     (hwdata[7:0]),
      .q       (rld_hi_reg)
   );

   // Interrupt enable byte; only the overflow bit acts
   sw_store_reg #(
      .WIDTH (8),
      .RESET (`TMR_IRQ_EN_RST)
   ) i_sw_store_reg_en (
      .hclk    (hclk),
      .hresetn (hresetn),
      .wr      (wr_en),
      .din     (hwdata[7:0]),
      .q       (irq_en_reg)
   );

   // Overflow interrupt enable bit
   assign overflow_irq_enable = irq_en_reg[`TMR_IRQ_BIT];

   // Interrupt level, registered from next-state values so it
   // changes at the same edge that stores the flag
   // flag or sticky status gated by enable
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= overflow_irq_enable && (ctrl_next[`TMR_FLAG_BIT] || status_next);
      end
   end

   // overflow as baud source, one pulse per rollover
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         baud_tick <= 1'b0;
      end else begin
         baud_tick <= rollover;
      end
   end

endmodule // autoreload_timer16
`default_nettype wire

// ---- test/autoreload_timer16_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module autoreload_timer16_monitor (
   input wire logic        hclk,         // Clock
   input wire logic        hresetn,      // Reset
   input wire logic        hsel,         // Select
   input wire logic [1:0]  htrans,       // Type
   input wire logic        hwrite,       // Write
   input wire logic        hready,       // Ready in
   input wire logic        overflow_ack, // Ack
   input wire logic [31:0] hrdata,       // Read data
   input wire logic        hreadyout,    // Ready out
   input wire logic        hresp,        // Response
   input wire logic        irq,          // Interrupt
   input wire logic        baud_tick     // Overflow pulse
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic take;
   logic wr_q;
   // Transfer taken; bench issues only word transfers
   assign take = hsel && htrans[1] && hready;
   // Marks a write data phase, where irq may legally change
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn) wr_q <= 1'b0;
      else wr_q <= take && hwrite;
   a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait");
   a_write_fast: assert property (take && hwrite |=> hreadyout)
      else $error("write wait");
   a_one_wait: assert property (!hreadyout |=> hreadyout)
      else $error("long wait");
   a_okay_resp: assert property (!hresp)
      else $error("bad resp");
   a_rdata_hold: assert property (!$stable(hrdata) |-> !$past(hreadyout))
      else $error("rdata moved");
   a_ack_clears: assert property (overflow_ack && !wr_q |=> !irq || baud_tick)
      else $error("ack kept irq");
   a_irq_holds: assert property (irq && !overflow_ack && !wr_q |=> irq)
      else $error("irq dropped");
   a_reset_quiet: assert property ($rose(hresetn) |-> hreadyout && !irq && !baud_tick)
      else $error("reset state");
endmodule // autoreload_timer16_monitor
bind autoreload_timer16 autoreload_timer16_monitor i_autoreload_timer16_monitor (.*);
`default_nettype wire

// ---- test/autoreload_timer16_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "autoreload_timer16_regs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module autoreload_timer16_tb;
   logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, overflow_ack = 1'h0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, irq, baud_tick;
   int          err_total = 0, tests_run = 0, cyc = 0, n;
   autoreload_timer16 i_autoreload_timer16 (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .overflow_ack, .hrdata, .hreadyout, .hresp,
      .irq, .baud_tick);
   // Clock; hang guard sized for the 65536-tick first rollover
   always #10 hclk = ~hclk;
   always @(posedge hclk) if (++cyc == 80000) begin
      err_total++;
      summarize();
   end
   task automatic summarize();
      if (err_total == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Single word transfer; waits for hready, no fixed latency assumed
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
      hsel <= 1'h1;
      hwrite <= w;
      htrans <= 2'h2;
      haddr <= {22'h0, idx, 2'h0};
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'h1);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] e);
      xfer(1'h0, idx, 32'h0);
      `CHK("rdata", e, hrdata)
   endtask
   // irq follows a landed write by at most one edge (one edge later for the enable); look once it has settled
   task automatic ck_irq(input logic e);
      repeat (2) @(posedge hclk);
      `CHK("irq", e, irq)
   endtask
   // Cycles until the next overflow pulse
   task automatic gap();
      n = 0;
      do begin @(posedge hclk); n++; end while (baud_tick !== 1'h1);
   endtask
   task automatic t_reset();
      rd(`TMR_CTRL_IDX, 32'h0);
      rd(`TMR_RLD_HI_IDX, 32'h0);
      xfer(1'h1, 8'hff, 32'h5);
      rd(8'hff, 32'h0);
   endtask
   task automatic t_reload();
      xfer(1'h1, `TMR_RLD_LO_IDX, 32'h5a);
      xfer(1'h1, `TMR_RLD_HI_IDX, 32'ha5);
      rd(`TMR_RLD_LO_IDX, 32'h5a);
      rd(`TMR_RLD_HI_IDX, 32'ha5);
      rd(`TMR_COUNT_IDX, 32'h0);
   endtask
   task automatic t_prescale();
      xfer(1'h1, `TMR_RLD_LO_IDX, 32'hff);
      xfer(1'h1, `TMR_RLD_HI_IDX, 32'hff);
      xfer(1'h1, `TMR_CTRL_IDX, 32'h08);
      gap();
      for (int ps = 0; ps < 8; ps++) begin
         xfer(1'h1, `TMR_CTRL_IDX, 32'h08 | ps);
         repeat (3) gap();
         `CHK("period", 1 << ps, n)
      end
      rd(`TMR_CTRL_IDX, 32'h1f);
      xfer(1'h1, `TMR_CTRL_IDX, 32'h0);
      rd(`TMR_COUNT_IDX, 32'hffff);
      xfer(1'h1, `TMR_RLD_LO_IDX, 32'hfd);
      xfer(1'h1, `TMR_CTRL_IDX, 32'h09);
      repeat (3) gap();
      `CHK("reload", 6, n)
   endtask
   task automatic t_irq();
      xfer(1'h1, `TMR_CTRL_IDX, 32'h10);
      ck_irq(1'h0);
      xfer(1'h1, `TMR_IRQ_EN_IDX, 32'h2);
      ck_irq(1'h1);
      overflow_ack <= 1'h1;
      @(posedge hclk);
      overflow_ack <= 1'h0;
      ck_irq(1'h0);
      rd(`TMR_CTRL_IDX, 32'h0);
      xfer(1'h1, `TMR_CTRL_IDX, 32'h10);
      ck_irq(1'h1);
      xfer(1'h1, `TMR_CTRL_IDX, 32'h09);
      gap();
      xfer(1'h1, `TMR_CTRL_IDX, 32'h0);
      rd(`TMR_STATUS_IDX, 32'h2);
      xfer(1'h1, `TMR_CLEAR_IDX, 32'h2);
      ck_irq(1'h0);
   endtask
   // Mid-run reset returns control and high reload to zero
   task automatic t_rerst();
      xfer(1'h1, `TMR_CTRL_IDX, 32'h1b);
      rd(`TMR_CTRL_IDX, 32'h1b);
      hresetn <= 1'h0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'h1;
      rd(`TMR_CTRL_IDX, 32'h0);
      rd(`TMR_RLD_HI_IDX, 32'h0);
   endtask
   // Reset, then the scenarios in turn
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'h1;
      t_reset();
      t_reload();
      t_prescale();
      t_irq();
      t_rerst();
      summarize();
   end
endmodule // autoreload_timer16_tb
`default_nettype wire
